/* File: src/rvs_pkg.sv */
// Constants and types for the reset, vector and start-up controller
package rvs_pkg;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int PIN_LOW_MIN_NS = 50;
    localparam int PIN_LOW_CYC    = (PIN_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_I = 7;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    localparam int NUM_IRQ = 5;
    localparam logic [9:0] VEC_RESET = 10'h000;

    localparam logic [3:0] START_SEL_SHIPPED = 4'h2;
    localparam int RT_SHORT_CYC = 1024;
    localparam int RT_LONG_CYC  = 16384;
    localparam int CK_6         = 6;
    localparam int CK_1K        = 1024;
    localparam int CK_16K       = 16384;
    localparam int CK_32K       = 32768;

    typedef enum logic [2:0] {
        ST_HOLD  = 3'b000,
        ST_RT    = 3'b001,
        ST_CK    = 3'b010,
        ST_RUN   = 3'b011,
        ST_SLEEP = 3'b100
    } rvs_state_t;

    typedef enum logic [1:0] {
        RT_NONE  = 2'b00,
        RT_SHORT = 2'b01,
        RT_LONG  = 2'b10
    } rvs_rt_t;

    typedef struct packed {
        logic       upd;
        logic [7:0] res;
        logic       carry;
        logic       ovf;
    } rvs_alu_t;

    typedef struct packed {
        logic       we;
        logic [7:0] data;
    } rvs_wr_t;

    typedef struct packed {
        rvs_rt_t     rt;
        logic [15:0] ck;
    } rvs_dly_t;
endpackage

/* File: src/rvs_ctrl.sv */
// Start-up sequencer, core flag register and vector selection
`timescale 1ns/10ps
module rvs_ctrl #(
    parameter int RT_LONG_P = rvs_pkg::RT_LONG_CYC,
    parameter int CK_16K_P  = rvs_pkg::CK_16K,
    parameter int CK_32K_P  = rvs_pkg::CK_32K
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ext_rst_n_i,
    input  wire logic              wdt_osc_i,
    input  wire logic              wdt_timeout_i,
    input  wire logic              sleep_i,
    input  wire logic              wake_i,
    input  wire logic [3:0]        clock_start_select_i,
    input  wire rvs_pkg::rvs_alu_t alu_i,
    input  wire rvs_pkg::rvs_wr_t  flag_wr_i,
    input  wire logic              reti_i,
    input  wire logic [4:0]        irq_i,
    input  wire logic [4:0]        irq_en_i,
    output logic                   core_rst_n_o,
    output logic                   core_run_o,
    output logic                   pc_load_o,
    output logic [9:0]             pc_vec_o,
    output logic [7:0]             core_flag_register_o
);
    import rvs_pkg::*;

    // Start-up delay for each select code
    function automatic rvs_dly_t dly_of(input logic [3:0] sel);
        rvs_dly_t r;
        r.rt = RT_NONE;
        r.ck = 16'(CK_6);
        case (sel)
            4'hf: r = '{RT_NONE,  16'(CK_1K)};
            4'he: r = '{RT_SHORT, 16'(CK_1K)};
            4'hd: r = '{RT_LONG,  16'(CK_1K)};
            4'hc: r = '{RT_NONE,  16'(CK_16K_P)};
            4'hb: r = '{RT_SHORT, 16'(CK_16K_P)};
            4'ha: r = '{RT_LONG,  16'(CK_16K_P)};
            4'h9: r = '{RT_LONG,  16'(CK_1K)};
            4'h8: r = '{RT_LONG,  16'(CK_32K_P)};
            4'h7: r = '{RT_NONE,  16'(CK_6)};
            4'h6: r = '{RT_SHORT, 16'(CK_6)};
            4'h5: r = '{RT_LONG,  16'(CK_6)};
            4'h4: r = '{RT_NONE,  16'(CK_6)};
            4'h3: r = '{RT_SHORT, 16'(CK_6)};
            4'h2: r = '{RT_LONG,  16'(CK_6)};
            4'h1: r = '{RT_NONE,  16'(CK_6)};
            default: r = '{RT_SHORT, 16'(CK_6)};
        endcase
        return r;
    endfunction

    // Lowest pending vector wins
    function automatic logic [9:0] vec_of(input logic [4:0] pend);
        logic [9:0] v;
        v = VEC_RESET;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (pend[i]) begin
                v = 10'(i + 1);
            end
        end
        return v;
    endfunction

    // Pin and oscillator synchronisers
    logic [2:0]  pin_s_q;
    logic        pin_lvl_q;
    logic        pin_lvl_d;
    logic [1:0]  low_cnt_q;
    logic [1:0]  low_cnt_d;
    logic [2:0]  osc_s_q;
    logic        osc_lvl_q;
    logic        osc_lvl_d;
    logic        osc_tick;
    logic        pin_req;
    logic        req;

    always_comb begin
        pin_lvl_d = pin_lvl_q;
        if (pin_s_q[1] == pin_s_q[2]) begin
            pin_lvl_d = pin_s_q[2];
        end
        osc_lvl_d = osc_lvl_q;
        if (osc_s_q[1] == osc_s_q[2]) begin
            osc_lvl_d = osc_s_q[2];
        end
        osc_tick = osc_lvl_d & ~osc_lvl_q;
        low_cnt_d = 2'h0;
        if (!pin_lvl_q) begin
            low_cnt_d = (low_cnt_q == 2'(PIN_LOW_CYC)) ? low_cnt_q : low_cnt_q + 2'h1;
        end
        pin_req = (low_cnt_q == 2'(PIN_LOW_CYC)) && !pin_lvl_q;
        req     = pin_req | wdt_timeout_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s_q   <= 3'h7;
            pin_lvl_q <= 1'b1;
            low_cnt_q <= 2'h0;
            // Start high: an oscillator already high at release is no edge
            osc_s_q   <= 3'h7;
            osc_lvl_q <= 1'b1;
        end else begin
            pin_s_q   <= {pin_s_q[1:0], ext_rst_n_i};
            pin_lvl_q <= pin_lvl_d;
            low_cnt_q <= low_cnt_d;
            osc_s_q   <= {osc_s_q[1:0], wdt_osc_i};
            osc_lvl_q <= osc_lvl_d;
        end
    end

    // Delay sequencer
    rvs_state_t  st_q;
    rvs_state_t  st_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [3:0]  start_sel_q;
    logic [3:0]  start_sel_d;
    logic        boot_q;
    logic        boot_d;
    rvs_dly_t    dly;
    rvs_dly_t    dly_in;
    logic [15:0] rt_last;
    logic [15:0] ck_seen_q;
    logic [15:0] ck_seen_d;

    always_comb begin
        dly     = dly_of(start_sel_q);
        dly_in  = dly_of(clock_start_select_i);
        rt_last = (dly.rt == RT_LONG) ? 16'(RT_LONG_P - 1) : 16'(RT_SHORT_CYC - 1);
        st_d    = st_q;
        cnt_d   = cnt_q;
        boot_d  = boot_q;
        start_sel_d = start_sel_q;
        // Cycles spent in the clock phase, independent of the delay counter
        ck_seen_d = (st_q == ST_CK) ? ck_seen_q + 16'h1 : 16'h0;
        case (st_q)
            ST_HOLD: begin
                cnt_d   = 16'h0;
                boot_d  = 1'b1;
                start_sel_d = clock_start_select_i;
                if (!req) begin
                    // Leaves the cycle after the pulse or pin release, on the new code
                    st_d = (dly_in.rt == RT_NONE) ? ST_CK : ST_RT;
                end
            end
            ST_RT: begin
                if (req) begin
                    st_d  = ST_HOLD;
                    cnt_d = 16'h0;
                end else if (osc_tick) begin
                    if (cnt_q == rt_last) begin
                        st_d  = ST_CK;
                        cnt_d = 16'h0;
                    end else begin
                        cnt_d = cnt_q + 16'h1;
                    end
                end
            end
            ST_CK: begin
                if (req) begin
                    st_d  = ST_HOLD;
                    cnt_d = 16'h0;
                end else if (cnt_q == dly.ck - 16'h1) begin
                    st_d   = ST_RUN;
                    boot_d = 1'b0;
                end else begin
                    cnt_d = cnt_q + 16'h1;
                end
            end
            ST_RUN: begin
                if (req) begin
                    st_d = ST_HOLD;
                end else if (sleep_i) begin
                    st_d = ST_SLEEP;
                end
            end
            default: begin
                if (req) begin
                    st_d = ST_HOLD;
                end else if (wake_i) begin
                    st_d  = ST_CK;
                    cnt_d = 16'h0;
                end
            end
        endcase
    end

    // Core control, vectors and flags
    logic       rst_n_d;
    logic       run_d;
    logic       take_d;
    logic       load_d;
    logic [9:0] vec_d;
    logic [7:0] flg_d;
    logic [4:0] pend;

    always_comb begin
        rst_n_d = (st_d == ST_RUN) || (st_d == ST_SLEEP) || (st_d == ST_CK && !boot_d);
        run_d   = (st_d == ST_RUN);
        pend    = irq_i & irq_en_i;
        take_d  = core_run_o && run_d && core_flag_register_o[FLG_I]
                  && (pend != 5'h0);
        load_d  = take_d || (boot_q && st_d == ST_RUN);
        vec_d   = take_d ? vec_of(pend) : VEC_RESET;
        flg_d   = core_flag_register_o;
        if (!core_rst_n_o) begin
            flg_d = FLAGS_RST;
        end else begin
            if (flag_wr_i.we) begin
                flg_d = flag_wr_i.data;
            end else if (alu_i.upd) begin
                flg_d[FLG_C] = alu_i.carry;
                flg_d[FLG_V] = alu_i.ovf;
                flg_d[FLG_N] = alu_i.res[7];
                flg_d[FLG_Z] = (alu_i.res == 8'h00);
            end
            // Only the global enable moves on entry and return
            if (take_d) begin
                flg_d[FLG_I] = 1'b0;
            end else if (reti_i) begin
                flg_d[FLG_I] = 1'b1;
            end
            flg_d[FLG_S] = flg_d[FLG_N] ^ flg_d[FLG_V];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Supply loss drops the core reset without waiting for a clock
            st_q                 <= ST_HOLD;
            cnt_q                <= 16'h0;
            start_sel_q          <= START_SEL_SHIPPED;
            ck_seen_q            <= 16'h0;
            boot_q               <= 1'b1;
            core_rst_n_o         <= 1'b0;
            core_run_o           <= 1'b0;
            pc_load_o            <= 1'b0;
            pc_vec_o             <= VEC_RESET;
            core_flag_register_o <= FLAGS_RST;
        end else begin
            st_q                 <= st_d;
            cnt_q                <= cnt_d;
            start_sel_q          <= start_sel_d;
            ck_seen_q            <= ck_seen_d;
            boot_q               <= boot_d;
            core_rst_n_o         <= rst_n_d;
            core_run_o           <= run_d;
            pc_load_o            <= load_d;
            pc_vec_o             <= vec_d;
            core_flag_register_o <= flg_d;
        end
    end

    property p_sign;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        core_flag_register_o[FLG_S] == (core_flag_register_o[FLG_N] ^ core_flag_register_o[FLG_V]);
    endproperty
    a_sign: assert property (p_sign) else $error("Sign flag mismatch");

    property p_zero;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (core_rst_n_o && alu_i.upd && !flag_wr_i.we) |=>
            core_flag_register_o[FLG_Z] == ($past(alu_i.res) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("Zero flag wrong");

    property p_neg_ovf;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (core_rst_n_o && alu_i.upd && !flag_wr_i.we) |=>
            core_flag_register_o[FLG_N] == $past(alu_i.res[7])
            && core_flag_register_o[FLG_V] == $past(alu_i.ovf)
            && core_flag_register_o[FLG_C] == $past(alu_i.carry);
    endproperty
    a_neg_ovf: assert property (p_neg_ovf) else $error("Flags not from result");

    property p_wdt;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wdt_timeout_i |=> !core_rst_n_o ##1 st_q != ST_HOLD;
    endproperty
    a_wdt: assert property (p_wdt) else $error("Watchdog reset not one cycle");

    property p_restart;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ((st_q == ST_RT || st_q == ST_CK) && req) |=> st_q == ST_HOLD && cnt_q == 16'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("Delay not restarted");

    property p_boot;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(core_rst_n_o) |-> pc_load_o && pc_vec_o == VEC_RESET && $past(st_q) == ST_CK;
    endproperty
    a_boot: assert property (p_boot) else $error("Release not at word 0");

    property p_prio;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (take_d && pend[0]) |=> pc_load_o && pc_vec_o == 10'h001 && !core_flag_register_o[FLG_I];
    endproperty
    a_prio: assert property (p_prio) else $error("Request 0 not preferred");

    property p_gate;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (pc_load_o && pc_vec_o != VEC_RESET) |-> $past(core_flag_register_o[FLG_I]);
    endproperty
    a_gate: assert property (p_gate) else $error("Taken with global enable off");

    property p_ck_end;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_CK && st_d == ST_RUN) |-> ck_seen_q == dly.ck - 16'h1;
    endproperty
    a_ck_end: assert property (p_ck_end) else $error("Clock count cut short");
endmodule

/* File: testbench/rvs_far_side.sv */
// Far-side model: reset pin and free-running watchdog oscillator
`timescale 1ns/10ps
module rvs_far_side (
    input  wire logic pin_hold_i,
    output logic      ext_rst_n_o,
    output logic      wdt_osc_o
);
    // Pin pulled up unless held low by the outside party
    assign ext_rst_n_o = ~pin_hold_i;

    // Unrelated to the system clock, 130 ns period
    initial begin
        wdt_osc_o = 1'b0;
        forever #65 wdt_osc_o = ~wdt_osc_o;
    end
endmodule

/* File: testbench/rvs_ctrl_bench.sv */
// Self-checking bench for start-up delay, flags and vectors
`timescale 1ns/10ps
module rvs_ctrl_bench;
    import rvs_pkg::*;
    localparam int LONG_P = 8;
    localparam int K16_P  = 16;
    localparam int K32_P  = 16;
    logic        core_clk_i;
    logic        rst_n_i;
    logic        pin_hold;
    logic        ext_rst_n;
    logic        wdt_osc;
    logic        wdt_timeout_i;
    logic        sleep_i;
    logic        wake_i;
    logic        reti_i;
    logic [3:0]  clock_start_select_i;
    rvs_alu_t    alu_i;
    rvs_wr_t     flag_wr_i;
    logic [4:0]  irq_i;
    logic [4:0]  irq_en_i;
    logic        core_rst_n_o;
    logic        core_run_o;
    logic        pc_load_o;
    logic [9:0]  pc_vec_o;
    logic [7:0]  flg;
    logic [7:0]  fl_m;
    logic [31:0] r;
    logic        tk;
    int          n_mismatch;
    int          n_compared;
    int          seed;
    int          lo;
    int          hi;
    int          n;

    rvs_far_side u_far (.pin_hold_i(pin_hold), .ext_rst_n_o(ext_rst_n), .wdt_osc_o(wdt_osc));

    rvs_ctrl #(.RT_LONG_P(LONG_P), .CK_16K_P(K16_P), .CK_32K_P(K32_P)) dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ext_rst_n_i(ext_rst_n),
        .wdt_osc_i(wdt_osc), .wdt_timeout_i(wdt_timeout_i), .sleep_i(sleep_i),
        .wake_i(wake_i), .clock_start_select_i(clock_start_select_i), .alu_i(alu_i),
        .flag_wr_i(flag_wr_i), .reti_i(reti_i), .irq_i(irq_i), .irq_en_i(irq_en_i),
        .core_rst_n_o(core_rst_n_o), .core_run_o(core_run_o), .pc_load_o(pc_load_o),
        .pc_vec_o(pc_vec_o), .core_flag_register_o(flg));

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Out of range reports the lower bound as expected
    task automatic chk_rng(input int got, input int lo_b, input int hi_b);
        chk(got, (got >= lo_b && got <= hi_b) ? got : lo_b);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask

    task automatic run_wait(output int cnt);
        cnt = 0;
        do begin
            @(negedge core_clk_i);
            cnt++;
            if (cnt > 20000) begin
                n_mismatch++;
                give_verdict();
            end
        end while (core_run_o !== 1'b1);
    endtask

    task automatic chk_rel(input int lo_b, input int hi_b);
        int cnt;
        run_wait(cnt);
        chk_rng(cnt, lo_b, hi_b);
        chk(pc_load_o, 1'b1);
        chk(pc_vec_o, VEC_RESET);
    endtask

    task automatic pulse_wdt;
        wdt_timeout_i = 1'b1;
        cyc(1);
        wdt_timeout_i = 1'b0;
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    function automatic int rt_of(input logic [3:0] c);
        case (c)
            4'h0, 4'h3, 4'h6, 4'hb, 4'he: return RT_SHORT_CYC;
            4'h2, 4'h5, 4'h9, 4'h8, 4'ha, 4'hd: return LONG_P;
            default: return 0;
        endcase
    endfunction

    function automatic int ck_of(input logic [3:0] c);
        case (c)
            4'h9, 4'hd, 4'he, 4'hf: return CK_1K;
            4'ha, 4'hb, 4'hc: return K16_P;
            4'h8: return K32_P;
            default: return CK_6;
        endcase
    endfunction

    // Oscillator edges cost 6.5 clocks each; margins cover sync and phase
    task automatic exp_win(input logic [3:0] c, output int lo_b, output int hi_b);
        int rt;
        rt = rt_of(c);
        lo_b = ck_of(c) + 1 + ((rt > 0) ? ((rt - 1) * 13) / 2 - 2 : 0);
        hi_b = ck_of(c) + 3 + ((rt > 0) ? (rt * 13) / 2 + 8 : 0);
    endtask

    function automatic logic [7:0] fx(input logic [7:0] d);
        return {d[7:5], d[2] ^ d[3], d[3:0]};
    endfunction

    function automatic logic [9:0] vec_of(input logic [4:0] p);
        vec_of = VEC_RESET;
        for (int i = 4; i >= 0; i--)
            if (p[i])
                vec_of = 10'(i + 1);
    endfunction

    initial begin
        seed = 65957;
        n_mismatch = 0;
        n_compared = 0;
        rst_n_i = 1'b0;
        pin_hold = 1'b0;
        wdt_timeout_i = 1'b0;
        sleep_i = 1'b0;
        wake_i = 1'b0;
        reti_i = 1'b0;
        clock_start_select_i = START_SEL_SHIPPED;
        alu_i = '0;
        flag_wr_i = '0;
        irq_i = 5'h00;
        irq_en_i = 5'h00;
        cyc(2);
        rst_n_i = 1'b1;
        exp_win(4'h2, lo, hi);
        chk_rel(lo, hi);
        chk(flg, 8'h00);
        done("power_on");
        for (int c = 15; c >= 0; c--) begin
            clock_start_select_i = 4'(c);
            pulse_wdt();
            exp_win(4'(c), lo, hi);
            chk_rel(lo, hi);
        end
        done("select_codes");
        clock_start_select_i = 4'h4;
        pulse_wdt();
        cyc(4);
        pulse_wdt();
        chk_rel(CK_6 + 1, CK_6 + 3);
        done("restart");
        clock_start_select_i = 4'h2;
        pin_hold = 1'b1;
        cyc(2);
        pin_hold = 1'b0;
        repeat (10) begin
            cyc(1);
            chk(core_rst_n_o, 1'b1);
        end
        pin_hold = 1'b1;
        cyc(30);
        chk(core_rst_n_o, 1'b0);
        pin_hold = 1'b0;
        exp_win(4'h2, lo, hi);
        chk_rel(lo + 1, hi + 6);
        done("pin");
        sleep_i = 1'b1;
        cyc(1);
        sleep_i = 1'b0;
        cyc(20);
        chk(core_run_o, 1'b0);
        wake_i = 1'b1;
        cyc(1);
        wake_i = 1'b0;
        run_wait(n);
        chk_rng(n, CK_6 - 2, CK_6 + 3);
        chk(core_rst_n_o, 1'b1);
        done("wake");
        fl_m = FLAGS_RST;
        repeat (40) begin
            r = $random(seed);
            alu_i = {r[0], r[15:8], r[16], r[17]};
            flag_wr_i = {r[1], r[31:24]};
            if (r[1])
                fl_m = fx(r[31:24]);
            else if (r[0])
                fl_m = fx({fl_m[7:4], r[17], r[15], r[15:8] == 8'h00, r[16]});
            cyc(1);
            chk(flg, fl_m);
        end
        alu_i = '0;
        flag_wr_i = '0;
        cyc(1);
        done("flags");
        repeat (40) begin
            r = $random(seed);
            flag_wr_i = {1'b1, r[7:0]};
            fl_m = fx(r[7:0]);
            cyc(1);
            flag_wr_i.we = 1'b0;
            irq_i = r[12:8];
            irq_en_i = r[17:13];
            cyc(1);
            tk = fl_m[7] && |(r[12:8] & r[17:13]);
            if (tk)
                fl_m[7] = 1'b0;
            chk(pc_load_o, tk);
            if (tk)
                chk(pc_vec_o, vec_of(r[12:8] & r[17:13]));
            chk(flg, fl_m);
            irq_i = 5'h00;
            reti_i = tk;
            cyc(1);
            reti_i = 1'b0;
            fl_m[7] = fl_m[7] | tk;
            chk(flg, fl_m);
        end
        done("vectors");
        cyc(3);
        rst_n_i = 1'b0;
        #1;
        chk(core_rst_n_o, 1'b0);
        chk(flg, FLAGS_RST);
        cyc(2);
        rst_n_i = 1'b1;
        exp_win(4'h2, lo, hi);
        chk_rel(lo, hi);
        done("power_loss");
        give_verdict();
    end
endmodule
